/* common/pps_cfg.svh */
// timing counts, field sizes and register map of the packet sequencer
`ifndef PPS_CFG_SVH
`define PPS_CFG_SVH
`define PPS_MODE_MAX 4'hD
`define PPS_CYC_NONE 8'h00
`define PPS_CYC_ONE_START 8'h0D
`define PPS_CYC_BOTH_START 8'h1D
`define PPS_CYC_SYNC_START 8'h14
`define PPS_CYC_EXIT 8'h03
`define PPS_CYC_IN_END 8'h16
`define PPS_PKT_MAX 7'h40
`define PPS_NBUF 2
`define PPS_REG_CTRL 4'h0
`define PPS_REG_PERIODS 4'h1
`define PPS_REG_STATUS 4'h2
`define PPS_REG_UNDERRUN 4'h3
`define PPS_REG_OVERRUN 4'h4
`define PPS_REG_IRQ_STAT 4'h5
`define PPS_REG_IRQ_MASK 4'h6
`define PPS_REG_FILL 4'h7
`endif

/* common/pps_pkg.sv */
// types of the periodic packet sequencer
package pps_pkg;
  typedef enum logic [3:0] {
    no_exchange_mode = 4'h0,
    host_to_device_only_mode = 4'h1,
    upload_first_mode = 4'h2,
    upload_last_mode = 4'h3,
    independent_dual_first_mode = 4'h4,
    lockstep_dual_mode = 4'h5,
    download_first_upload_last_mode = 4'h6,
    fixed_pattern_only_mode = 4'h7
  } pps_mode_t;

  typedef struct packed {
    logic out_en;
    logic out_const;
    logic in_en;
    logic in_at_end;
    logic lockstep;
  } pps_dec_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_USER = 3'b011,
    ST_END = 3'b010,
    ST_STALL_OUT = 3'b110,
    ST_STALL_IN = 3'b111
  } pps_state_t;
endpackage : pps_pkg

/* logic/pps_overhead.sv */
// overhead countdown timer in instruction cycles
`timescale 1ns/1ps
module pps_overhead #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic busy
);
  logic [W-1:0] cnt_ff;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (load) begin
      cnt_ff <= count;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end
  assign busy = load | (cnt_ff != '0);
endmodule : pps_overhead

/* logic/pps_sequencer.sv */
// periodic packet buffer sequencer: mode decode, buffer rotation, stalls
// Contract
// - mode 0..13 plus three tuning values
// - mode 0: no exchange, 0/3 cycles
// - download buffers serviced only at start
// - true download in modes 1,4,5,6
// - consumed download buffer freed, rotate
// - empty download buffer: stall, count underrun
// - upload serviced in 2-6, 8-13
// - upload before or after user program
// - filled upload buffer marked ready, rotate
// - unsent upload buffer: stall, count overrun
// - lockstep swap together, 20 cycles
// - overhead 13, 29 and 22 cycles
// - constant buffer read like true packets; modes 8,10,12 charge 26 start cycles (13+13), not 29
// - modes 8-13 constant plus upload
// - equal packet lengths, at most 64
`timescale 1ns/1ps
`include "pps_cfg.svh"
module pps_sequencer #(
  parameter int NBUF = `PPS_NBUF,
  parameter int CW = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic period_tick,
  input wire logic user_done,
  output logic user_go,
  input wire logic out_consumed,
  input wire logic in_filled,
  input wire logic host_out_fill,
  input wire logic host_in_drain,
  output logic [NBUF-1:0] out_free,
  output logic [NBUF-1:0] in_ready,
  output logic out_cur,
  output logic in_cur,
  output logic irq
);
  localparam int BW = (NBUF > 1) ? $clog2(NBUF) : 1;

  logic [3:0] mode_ff;
  logic run_ff;
  logic [7:0] out_per_ff, in_per_ff;
  logic [6:0] const_len_ff;
  logic [NBUF-1:0] out_full_ff, in_full_ff;
  logic [BW-1:0] out_idx_ff, in_idx_ff;
  logic [CW-1:0] under_ff, over_ff;
  logic [1:0] ist_ff, imask_ff;
  logic user_go_ff;
  pps_pkg::pps_state_t st_ff, nxt_st;

  // mode to direction flags
  function automatic pps_pkg::pps_dec_t dec_mode(input logic [3:0] m);
    pps_pkg::pps_dec_t d;
    d = '0;
    d.out_en = (m == 4'h1) || (m >= 4'h4 && m <= 4'h6);
    d.out_const = (m >= 4'h7 && m <= `PPS_MODE_MAX);
    d.in_en = (m >= 4'h2 && m <= 4'h6) || (m >= 4'h8 && m <= `PPS_MODE_MAX);
    d.in_at_end = (m == 4'h3) || (m == 4'h6) || (m >= 4'h9 && m[0]);
    d.lockstep = (m == 4'h5);
    return d;
  endfunction : dec_mode

  function automatic logic [BW-1:0] next_idx(input logic [BW-1:0] i);
    return (i == BW'(NBUF - 1)) ? '0 : i + 1'b1;
  endfunction : next_idx

  wire pps_pkg::pps_dec_t dm = dec_mode(mode_ff);
  wire out_live = dm.out_en;
  wire in_start = dm.in_en && !dm.in_at_end;
  wire in_last = dm.in_en && dm.in_at_end;
  // start overhead per mode; constant buffer part modelled as one-direction cost
  wire [7:0] start_cyc = dm.lockstep ? `PPS_CYC_SYNC_START :
    (out_live && in_start) ? `PPS_CYC_BOTH_START :
    ((out_live || in_start) && (dm.out_const && in_start)) ? `PPS_CYC_ONE_START + 8'h0D :
    (out_live || in_start || dm.out_const) ? `PPS_CYC_ONE_START : `PPS_CYC_NONE;
  wire [7:0] end_cyc = in_last ? `PPS_CYC_IN_END : `PPS_CYC_EXIT;

  // rotation decisions
  wire out_swap = out_live && out_consumed;
  wire [BW-1:0] out_nidx = out_swap ? next_idx(out_idx_ff) : out_idx_ff;
  wire in_swap = in_filled;
  wire [BW-1:0] in_nidx = in_swap ? next_idx(in_idx_ff) : in_idx_ff;
  wire at_start = (st_ff == pps_pkg::ST_IDLE) && run_ff && period_tick;
  wire at_end = (st_ff == pps_pkg::ST_USER) && user_done;
  wire do_out = at_start && out_live;
  wire do_in = (at_start && in_start) || (at_end && in_last);
  wire out_fill_hit = host_out_fill && (st_ff != pps_pkg::ST_STALL_OUT || 1'b1);
  wire out_empty_next = !out_full_ff[out_nidx];
  wire in_busy_next = in_full_ff[in_nidx] && !host_in_drain;
  wire under_ev = do_out && out_swap && out_empty_next && !host_out_fill;
  wire over_ev = do_in && in_swap && in_busy_next;
  wire timer_busy;
  wire timer_load = at_start || at_end;
  wire [7:0] timer_cnt = at_start ? start_cyc : end_cyc;

  pps_overhead #(.W(8)) u_ovh (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(timer_load),
    .count(timer_cnt),
    .busy(timer_busy)
  );

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      pps_pkg::ST_IDLE: if (at_start) nxt_st = under_ev ? pps_pkg::ST_STALL_OUT :
        (over_ev && in_start) ? pps_pkg::ST_STALL_IN : pps_pkg::ST_START;
      pps_pkg::ST_STALL_OUT: if (out_full_ff[out_idx_ff])
        nxt_st = in_start && in_full_ff[in_idx_ff] ? pps_pkg::ST_STALL_IN : pps_pkg::ST_START;
      pps_pkg::ST_STALL_IN: if (!in_full_ff[in_idx_ff])
        nxt_st = in_last ? pps_pkg::ST_END : pps_pkg::ST_START;
      pps_pkg::ST_START: if (!timer_busy) nxt_st = pps_pkg::ST_USER;
      pps_pkg::ST_USER: if (user_done) nxt_st = over_ev && in_last ?
        pps_pkg::ST_STALL_IN : pps_pkg::ST_END;
      pps_pkg::ST_END: if (!timer_busy) nxt_st = pps_pkg::ST_IDLE;
      default: nxt_st = pps_pkg::ST_IDLE;
    endcase
  end

  // register decode
  wire wr_ctrl = reg_wr && reg_addr == `PPS_REG_CTRL;
  wire wr_per = reg_wr && reg_addr == `PPS_REG_PERIODS;
  wire wr_ist = reg_wr && reg_addr == `PPS_REG_IRQ_STAT;
  wire wr_imask = reg_wr && reg_addr == `PPS_REG_IRQ_MASK;
  wire mode_ok = reg_wdata[3:0] <= `PPS_MODE_MAX;
  // lockstep with one count given copies it to both directions
  wire [7:0] w_out_per = reg_wdata[7:0];
  wire [7:0] w_in_per = reg_wdata[15:8];
  wire lock_w = mode_ff == 4'h5;
  wire [7:0] nxt_out_per = (lock_w && w_out_per == 8'h00) ? w_in_per : w_out_per;
  wire [7:0] nxt_in_per = (lock_w && w_in_per == 8'h00) ? w_out_per : w_in_per;
  wire [6:0] w_len = reg_wdata[22:16] > `PPS_PKT_MAX ? `PPS_PKT_MAX : reg_wdata[22:16];
  wire [31:0] rd_mux =
    reg_addr == `PPS_REG_CTRL ? {27'h0, run_ff, mode_ff} :
    reg_addr == `PPS_REG_PERIODS ? {9'h0, const_len_ff, in_per_ff, out_per_ff} :
    reg_addr == `PPS_REG_STATUS ? {29'h0, st_ff} :
    reg_addr == `PPS_REG_UNDERRUN ? 32'(under_ff) :
    reg_addr == `PPS_REG_OVERRUN ? 32'(over_ff) :
    reg_addr == `PPS_REG_IRQ_STAT ? {30'h0, ist_ff} :
    reg_addr == `PPS_REG_IRQ_MASK ? {30'h0, imask_ff} :
    reg_addr == `PPS_REG_FILL ? {16'h0, 8'(in_full_ff), 8'(out_full_ff)} : 32'h0;

  // per-buffer fill flags; a set wins over a clear on the same buffer
  logic [NBUF-1:0] nxt_out_full, nxt_in_full;
  always_comb begin
    nxt_out_full = out_full_ff;
    nxt_in_full = in_full_ff;
    if (do_out && out_swap && !dm.out_const) nxt_out_full[out_idx_ff] = 1'b0;
    if (host_out_fill && !out_full_ff[out_idx_ff]) nxt_out_full[out_idx_ff] = 1'b1;
    else if (host_out_fill) nxt_out_full[out_nidx] = 1'b1;
    if (host_in_drain) nxt_in_full[in_idx_ff] = 1'b0;
    if (do_in && in_swap) nxt_in_full[in_idx_ff] = 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode_ff <= 4'h0;
      run_ff <= 1'b0;
      out_per_ff <= 8'h00;
      in_per_ff <= 8'h00;
      const_len_ff <= 7'h00;
      imask_ff <= 2'h0;
    end else begin
      if (wr_ctrl && mode_ok) mode_ff <= reg_wdata[3:0];
      if (wr_ctrl) run_ff <= reg_wdata[4];
      if (wr_per) begin
        out_per_ff <= nxt_out_per;
        in_per_ff <= nxt_in_per;
        const_len_ff <= w_len;
      end
      if (wr_imask) imask_ff <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_ff <= pps_pkg::ST_IDLE;
      out_idx_ff <= '0;
      in_idx_ff <= '0;
      out_full_ff <= '0;
      in_full_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      out_full_ff <= nxt_out_full;
      in_full_ff <= nxt_in_full;
      if (do_out) out_idx_ff <= out_nidx;
      if (do_in) in_idx_ff <= in_nidx;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      under_ff <= '0;
      over_ff <= '0;
      ist_ff <= 2'h0;
      reg_rdata <= 32'h0;
      user_go_ff <= 1'b0;
    end else begin
      if (under_ev) under_ff <= under_ff + 1'b1;
      if (over_ev) over_ff <= over_ff + 1'b1;
      ist_ff <= (ist_ff & ~(wr_ist ? reg_wdata[1:0] : 2'h0)) | {over_ev, under_ev};
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
      user_go_ff <= (st_ff == pps_pkg::ST_START) && !timer_busy;
    end
  end

  assign user_go = user_go_ff;
  assign out_cur = out_idx_ff[0];
  assign in_cur = in_idx_ff[0];
  assign out_free = ~out_full_ff;
  assign in_ready = in_full_ff;
  assign irq = |(ist_ff & imask_ff);
  wire unused_ok = out_fill_hit;
endmodule : pps_sequencer

/* verif/pps_host_model.sv */
// host side model: refills download buffers, drains upload buffers
`timescale 1ns/1ps
module pps_host_model #(
  parameter int NBUF = 2
) (
  input wire logic core_clk, rst_n, hold_out, hold_in,
  input wire logic [NBUF-1:0] out_free, in_ready,
  output logic host_out_fill, host_in_drain
);
  // a gap after each pulse lets the flags settle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      host_out_fill <= 1'b0;
      host_in_drain <= 1'b0;
    end else begin
      host_out_fill <= |out_free && !hold_out && !host_out_fill;
      host_in_drain <= |in_ready && !hold_in && !host_in_drain;
    end
  end
endmodule : pps_host_model

/* verif/pps_sequencer_checker.sv */
// port assertions of the packet sequencer
`timescale 1ns/1ps
module pps_sequencer_checker #(
  parameter int NBUF = 2
) (
  input wire logic core_clk, rst_n, reg_wr, reg_rd, period_tick, user_done,
  input wire logic out_consumed, in_filled, host_out_fill, host_in_drain,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata, reg_rdata,
  input wire logic user_go, out_cur, in_cur, irq,
  input wire logic [NBUF-1:0] out_free, in_ready
);
  logic [3:0] mode_ff;
  logic [1:0] mask_ff;
  logic [5:0] gcnt_ff;
  logic seen_ff, user_ff;
  logic [5:0] need;
  // least start overhead of the mode in force
  assign need = (mode_ff == 4'h4) ? 6'h1D : (mode_ff == 4'h5) ? 6'h14 :
    (mode_ff == 4'h0 || mode_ff == 4'h3) ? 6'h00 : 6'h0D;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode_ff <= 4'h0;
      mask_ff <= 2'h0;
      gcnt_ff <= 6'h00;
      seen_ff <= 1'b0;
      user_ff <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 4'h0 && reg_wdata[3:0] <= 4'hD)
        mode_ff <= reg_wdata[3:0];
      if (reg_wr && reg_addr == 4'h6)
        mask_ff <= reg_wdata[1:0];
      gcnt_ff <= period_tick ? 6'h01 : gcnt_ff + {5'h00, gcnt_ff != 6'h3F};
      seen_ff <= period_tick || (seen_ff && !user_go);
      user_ff <= user_go || (user_ff && !user_done);
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_go_pulse: assert property (user_go |=> !user_go)
    else $error("user start longer than one cycle");
  a_go_after_tick: assert property (user_go |-> seen_ff)
    else $error("user start without period start");
  a_start_overhead: assert property (user_go |-> gcnt_ff >= need)
    else $error("start overhead too short");
  a_one_program: assert property (user_go |-> !user_ff)
    else $error("user start while program runs");
  a_exit_gap: assert property (user_done |-> !user_go [*4])
    else $error("exit overhead too short");
  a_out_rotate: assert property ($changed(out_cur) |-> mode_ff inside {4'h1, [4'h4:4'hD]})
    else $error("download rotation in wrong mode");
  a_in_rotate: assert property ($changed(in_cur) |-> mode_ff inside {[4'h2:4'h6], [4'h8:4'hD]})
    else $error("upload rotation in wrong mode");
  a_irq_masked: assert property (mask_ff == 2'h0 |-> !irq)
    else $error("interrupt while fully masked");
  c_lockstep: cover property (user_go && mode_ff == 4'h5);
  c_out_rot: cover property ($changed(out_cur));
  c_in_rot: cover property ($changed(in_cur));
endmodule : pps_sequencer_checker

bind pps_sequencer pps_sequencer_checker #(.NBUF(NBUF)) pps_sequencer_checker_i (
  .core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .period_tick(period_tick), .user_done(user_done), .out_consumed(out_consumed),
  .in_filled(in_filled), .host_out_fill(host_out_fill), .host_in_drain(host_in_drain),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .user_go(user_go),
  .out_cur(out_cur), .in_cur(in_cur), .irq(irq), .out_free(out_free), .in_ready(in_ready)
);

/* verif/pps_sequencer_tb_top.sv */
// self-checking bench of the packet sequencer
`timescale 1ns/1ps
module pps_sequencer_tb_top;
  logic core_clk, rst_n, reg_wr, reg_rd, period_tick, user_done, user_go;
  logic out_consumed, in_filled, host_out_fill, host_in_drain, hold_out, hold_in;
  logic out_cur, in_cur, irq;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [1:0] out_free, in_ready;
  int error_cnt = 0;
  int samples_checked = 0;
  pps_sequencer pps_sequencer_i (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .period_tick(period_tick), .user_done(user_done), .user_go(user_go),
    .out_consumed(out_consumed), .in_filled(in_filled), .host_out_fill(host_out_fill),
    .host_in_drain(host_in_drain), .out_free(out_free), .in_ready(in_ready),
    .out_cur(out_cur), .in_cur(in_cur), .irq(irq));
  pps_host_model pps_host_model_i (.core_clk(core_clk), .rst_n(rst_n), .hold_out(hold_out),
    .hold_in(hold_in), .out_free(out_free), .in_ready(in_ready),
    .host_out_fill(host_out_fill), .host_in_drain(host_in_drain));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic end_sim;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rdv(input logic [3:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
    @(posedge core_clk);
  endtask : rdv
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rdv(a, v);
    chk(v, exp);
  endtask : rd
  // one period; a stall frees the held host after 300 cycles
  task automatic period(input logic cons, input logic fill);
    int n;
    out_consumed <= cons;
    in_filled <= fill;
    period_tick <= 1'b1;
    @(posedge core_clk);
    period_tick <= 1'b0;
    for (n = 0; n < 600 && user_go !== 1'b1; n++) begin
      if (n == 300)
        {hold_out, hold_in} <= 2'b00;
      @(posedge core_clk);
    end
    if (n == 600) begin
      chk(32'h0, 32'h1);
      end_sim();
    end
    repeat ($urandom_range(8, 1)) @(posedge core_clk);
    user_done <= 1'b1;
    @(posedge core_clk);
    user_done <= 1'b0;
    repeat (40) @(posedge core_clk);
  endtask : period
  task automatic stall(input logic [31:0] ctl, input logic [31:0] b);
    logic [31:0] c0, c1;
    wr(4'h0, ctl);
    wr(4'h5, 32'h3);
    wr(4'h6, b);
    rdv(b[0] ? 4'h3 : 4'h4, c0);
    {hold_in, hold_out} <= b[1:0];
    repeat (3) period(b[0], b[1]);
    rdv(b[0] ? 4'h3 : 4'h4, c1);
    chk({31'h0, c1 > c0}, 32'h1);
    rd(4'h5, b);
    chk({31'h0, irq}, 32'h1);
    wr(4'h6, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(4'h5, b);
    rd(4'h5, 32'h0);
  endtask : stall
  function automatic bit in_on(input int m);
    return m inside {[2:6], [8:13]};
  endfunction : in_on
  initial begin
    logic [31:0] u0, o0, u1, o1;
    logic oc, ic;
    {rst_n, reg_wr, reg_rd, period_tick, user_done, out_consumed, in_filled} = 7'h00;
    {hold_out, hold_in, reg_addr, reg_wdata} = 38'h0;
    void'($urandom(78670));
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    for (int a = 0; a < 16; a++)
      if (a != 7)
        rd(4'(a), 32'h0);
    wr(4'h0, 32'h15);
    wr(4'h0, 32'h0E);
    rd(4'h0, 32'h05);
    wr(4'h1, 32'h007F0403);
    rd(4'h1, 32'h00400403);
    for (int m = 0; m < 14; m++) begin
      wr(4'h1, m == 0 ? 32'h0 : 32'h00000404);
      wr(4'h0, 32'h10 | 32'(m));
      rdv(4'h3, u0);
      rdv(4'h4, o0);
      oc = out_cur;
      ic = in_cur;
      hold_out <= m >= 7;
      repeat (4) period(1'($urandom_range(1)), 1'($urandom_range(1)));
      rdv(4'h3, u1);
      rdv(4'h4, o1);
      if (!(m inside {1, [4:6]}))
        chk(u1, u0);
      if (m inside {0, 2, 3})
        chk({31'h0, out_cur}, {31'h0, oc});
      if (!in_on(m))
        chk({o1[30:0], in_cur}, {o0[30:0], ic});
      rd(4'h2, 32'h0);
    end
    stall(32'h11, 32'h1);
    stall(32'h12, 32'h2);
    end_sim();
  end
endmodule : pps_sequencer_tb_top
